//--- src/ctg_pkg.sv
// Package for the cascaded timer and carrier generator.
// Assumes an APB slave with 32-bit aligned word registers.
package ctg_pkg;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [11:0] ADDR_LOWER_MODE    = 12'hF90;
	localparam logic [11:0] ADDR_UPPER_MODE    = 12'hFA8;
	localparam logic [11:0] ADDR_UPPER_MODULO  = 12'hF00;
	localparam logic [11:0] ADDR_LOWER_MODULO  = 12'hF04;
	localparam logic [11:0] ADDR_HIGH_MODULO   = 12'hF08;
	localparam logic [11:0] ADDR_OUTPUT_CTRL   = 12'hF0C;
	localparam logic [11:0] ADDR_STATUS        = 12'hF10;
	localparam logic [11:0] ADDR_COUNTS        = 12'hF14;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int MODE_M0_BIT     = 0;
	localparam int MODE_M1_BIT     = 1;
	localparam int MODE_ENABLE_BIT = 2;
	localparam int MODE_START_BIT  = 3;
	localparam int MODE_SEL_LSB    = 4;
	localparam int CTRL_LOWER_OE_BIT   = 0;
	localparam int CTRL_STYLE_BIT      = 1;
	localparam int CTRL_NEXT_LEVEL_BIT = 2;
	localparam int CTRL_LEVEL_BIT      = 3;
	localparam int CTRL_UPPER_OE_BIT   = 4;
	localparam int STAT_UPPER_IRQ_BIT  = 0;
	localparam int STAT_LOWER_IRQ_BIT  = 1;
	localparam int STAT_UPPER_IE_BIT   = 2;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] MODE_RESET   = 8'h00;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] MODULO_RESET = 8'hFF;
	// ****************************************
	// Tick selection codes and divider width
	// ****************************************
	localparam logic [2:0] SEL_CODE_2 = 3'h2;
	localparam logic [2:0] SEL_CODE_3 = 3'h3;
	localparam logic [2:0] SEL_CODE_4 = 3'h4;
	localparam logic [2:0] SEL_CODE_5 = 3'h5;
	localparam logic [2:0] SEL_CODE_6 = 3'h6;
	localparam logic [2:0] SEL_CODE_7 = 3'h7;
	localparam int PRESCALE_WIDTH = 12;
	typedef enum logic [1:0] {
		CTG_MODE_OTHER,
		CTG_MODE_CASCADE,
		CTG_MODE_CARRIER
	} ctg_mode_t;
endpackage

//--- src/ctg_prescaler.sv
// Free running prescaler producing one-cycle taps of fx/2^(k+1).
// Assumes pclk is the system oscillator fx.
`timescale 1ns/100ps
`default_nettype none
module ctg_prescaler
	import ctg_pkg::*;
#(
	parameter int W = PRESCALE_WIDTH
) (
	input  wire logic pclk,
	input  wire logic presetn,
	ctg_tick_if.src   ticks
);
	logic [W-1:0] div_q;
	logic [W-1:0] div_d;

	assign div_d = div_q + 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// Tap k pulses when the low k+1 bits roll over
	always_comb begin
		for (int k = 0; k < W; k++) begin
			ticks.tap[k] = &(div_q | ~((W'(1) << (k + 1)) - W'(1)));
		end
	end
endmodule
`default_nettype wire

//--- src/ctg_tick_if.sv
// Interface carrying prescaler tick pulses between design modules.
// Assumes a single clock; every tick is a one-cycle enable.
`timescale 1ns/100ps
`default_nettype none
interface ctg_tick_if #(parameter int W = 12);
	logic [W-1:0] tap;
	modport src (output tap);
	modport dst (input tap);
endinterface
`default_nettype wire

//--- src/ctg_top.sv
// Cascaded 8-bit timer pair with 16-bit and carrier generator modes.
// Assumes an APB master on pclk; pins drive a remote-control load.
// Notes on behaviour
// - Cascade: lower channel counts ticks, its overflow ticks the upper channel.
// - Cascade: each channel compares with its own modulo, separate matches.
// - Both matches together set lower flag and toggle output flip-flop.
// - Cascade interval interrupt repeats while counting continues.
// - Lower select: 2 fx/2, 3 fx, 4 fx/1024, 5 fx/256, 6 fx/64, 7 fx/16.
// - Upper select 2 chains or carrier; 3..7 fx/32,/4096,/1024,/256,/64.
// - Start bit clears counter and flag, counts if enable set.
// - Start bit three is never stored and always reads back zero.
// - Enable zero holds count, one lets it count; cascade ignores the upper enable.
// - Cascade selected when upper mode bits 10b and lower mode bits 10b.
// - Carrier mode: lower makes carrier, upper times the envelope.
// - Reset clears both mode registers, upper output enable and control.
// - Level one: pin gets carrier when style zero, steady high when one.
// - Level zero: pin low, carrier suppressed.
// - Buffer bit copied into level bit on each upper interrupt in carrier mode.
// - Longest time is reached with both modulos at all ones.
// - Carrier: lower toggles on match, alternates high and low modulo.
// - Carrier: upper match sets its flag, toggles, reloads level bit.
// - Gated output switches only at carrier pulse boundaries.
// - Output enable zero holds the pin low.
`timescale 1ns/100ps
`default_nettype none
module ctg_top
	import ctg_pkg::*;
#(
	parameter int PW = PRESCALE_WIDTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        upper_irq_ack,
	input  wire logic        lower_irq_ack,
	output logic             upper_irq,
	output logic             lower_irq,
	output logic             carrier_out_pin,
	output logic             envelope_out_pin
);
	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0] upper_channel_mode_q;
	logic [7:0] lower_channel_mode_q;
	logic [7:0] upper_modulo_q;
	logic [7:0] lower_modulo_q;
	logic [7:0] high_period_modulo_q;
	logic [7:0] output_control_reg_q;
	logic       upper_output_enable_q;
	logic       upper_channel_irq_enable_q;
	logic       upper_channel_irq_flag_q;
	logic       lower_channel_irq_flag_q;
	logic [7:0] upper_count_q;
	logic [7:0] lower_count_q;
	logic       upper_tff_q;
	logic       output_toggle_ff_q;
	logic       phase_high_q;
	logic       gated_q;
	logic [31:0] prdata_q;

	ctg_tick_if #(.W(PW)) ticks ();

	ctg_prescaler #(.W(PW)) u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.ticks   (ticks)
	);

	// ****************************************
	// Decode
	// ****************************************
	logic      wr_acc;
	logic      rd_acc;
	logic      known;
	ctg_mode_t mode;

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign known  = paddr inside {ADDR_LOWER_MODE, ADDR_UPPER_MODE, ADDR_UPPER_MODULO,
		ADDR_LOWER_MODULO, ADDR_HIGH_MODULO, ADDR_OUTPUT_CTRL, ADDR_STATUS, ADDR_COUNTS};

	function automatic logic is_write(input logic [11:0] a);
		return wr_acc && paddr == a && pstrb[0];
	endfunction

	// Tap index k gives fx/2^(k+1)
	function automatic logic pick(input logic [PW-1:0] t, input int div_log2);
		return (div_log2 == 0) ? 1'b1 : t[div_log2 - 1];
	endfunction

	always_comb begin
		mode = CTG_MODE_OTHER;
		if (upper_channel_mode_q[MODE_M1_BIT] && !upper_channel_mode_q[MODE_M0_BIT]
			&& lower_channel_mode_q[MODE_M1_BIT] && !lower_channel_mode_q[MODE_M0_BIT]) begin
			mode = CTG_MODE_CASCADE;
		end else if (!upper_channel_mode_q[MODE_M1_BIT] && !upper_channel_mode_q[MODE_M0_BIT]
			&& lower_channel_mode_q[MODE_M1_BIT] && lower_channel_mode_q[MODE_M0_BIT]) begin
			mode = CTG_MODE_CARRIER;
		end
	end

	// ****************************************
	// Tick selection
	// ****************************************
	logic lower_tick;
	logic upper_tick;
	logic lower_run;
	logic upper_run;
	logic lower_ovf;
	logic carrier_edge;
	logic [2:0] lsel;
	logic [2:0] usel;

	assign lsel = lower_channel_mode_q[MODE_SEL_LSB +: 3];
	assign usel = upper_channel_mode_q[MODE_SEL_LSB +: 3];

	always_comb begin
		unique case (lsel)
			SEL_CODE_2: lower_tick = pick(ticks.tap, 1);
			SEL_CODE_3: lower_tick = pick(ticks.tap, 0);
			SEL_CODE_4: lower_tick = pick(ticks.tap, 10);
			SEL_CODE_5: lower_tick = pick(ticks.tap, 8);
			SEL_CODE_6: lower_tick = pick(ticks.tap, 6);
			SEL_CODE_7: lower_tick = pick(ticks.tap, 4);
			default:    lower_tick = 1'b0;
		endcase
	end

	always_comb begin
		unique case (usel)
			SEL_CODE_2: upper_tick = (mode == CTG_MODE_CASCADE) ? lower_ovf : carrier_edge;
			SEL_CODE_3: upper_tick = pick(ticks.tap, 5);
			SEL_CODE_4: upper_tick = pick(ticks.tap, 12);
			SEL_CODE_5: upper_tick = pick(ticks.tap, 10);
			SEL_CODE_6: upper_tick = pick(ticks.tap, 8);
			SEL_CODE_7: upper_tick = pick(ticks.tap, 6);
			default:    upper_tick = 1'b0;
		endcase
	end

	assign lower_run = lower_channel_mode_q[MODE_ENABLE_BIT] & lower_tick;
	assign upper_run = (upper_channel_mode_q[MODE_ENABLE_BIT] || mode == CTG_MODE_CASCADE)
		& upper_tick;

	// ****************************************
	// Compare logic
	// ****************************************
	logic lower_match;
	logic upper_match;
	logic cascade_hit;
	logic lower_start;
	logic upper_start;
	logic [7:0] lower_cmp;

	assign lower_start = is_write(ADDR_LOWER_MODE) && pwdata[MODE_START_BIT];
	assign upper_start = is_write(ADDR_UPPER_MODE) && pwdata[MODE_START_BIT];
	assign lower_cmp   = (mode == CTG_MODE_CARRIER && phase_high_q) ? high_period_modulo_q
		: lower_modulo_q;
	assign lower_match = lower_run && lower_count_q == lower_cmp;
	assign upper_match = upper_run && upper_count_q == upper_modulo_q;
	assign lower_ovf   = lower_run && lower_count_q == lower_modulo_q;
	assign cascade_hit = (mode == CTG_MODE_CASCADE) && lower_ovf
		&& upper_count_q == upper_modulo_q;
	assign carrier_edge = lower_match && !phase_high_q;

	// Lower channel counter, wraps to zero at match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_count_q <= 8'h00;
		end else if (lower_start) begin
			lower_count_q <= 8'h00;
		end else if (lower_match || lower_ovf) begin
			lower_count_q <= 8'h00;
		end else if (lower_run) begin
			lower_count_q <= lower_count_q + 8'h01;
		end
	end

	// Upper channel counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_count_q <= 8'h00;
		end else if (upper_start || (mode == CTG_MODE_CASCADE && lower_start)) begin
			upper_count_q <= 8'h00;
		end else if (upper_match) begin
			upper_count_q <= 8'h00;
		end else if (upper_run) begin
			upper_count_q <= upper_count_q + 8'h01;
		end
	end

	// Carrier phase and lower toggle flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_high_q       <= 1'b1;
			output_toggle_ff_q <= 1'b0;
		end else if (lower_start) begin
			phase_high_q       <= 1'b1;
			output_toggle_ff_q <= 1'b0;
		end else if (mode == CTG_MODE_CARRIER && lower_match) begin
			phase_high_q       <= ~phase_high_q;
			output_toggle_ff_q <= ~output_toggle_ff_q;
		end else if (cascade_hit) begin
			output_toggle_ff_q <= ~output_toggle_ff_q;
		end
	end

	// Upper toggle flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_tff_q <= 1'b0;
		end else if (upper_start) begin
			upper_tff_q <= 1'b0;
		end else if (mode == CTG_MODE_CARRIER && upper_match) begin
			upper_tff_q <= ~upper_tff_q;
		end
	end

	// ****************************************
	// Interrupt flags, set wins over clear
	// ****************************************
	logic lower_set;
	logic upper_set;
	logic stat_wr;

	assign lower_set = cascade_hit || (mode == CTG_MODE_CARRIER && carrier_edge)
		|| (mode == CTG_MODE_OTHER && lower_match);
	assign upper_set = upper_match && mode != CTG_MODE_CASCADE;
	assign stat_wr   = is_write(ADDR_STATUS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_channel_irq_flag_q <= 1'b0;
		end else if (lower_set) begin
			lower_channel_irq_flag_q <= 1'b1;
		end else if (lower_start || lower_irq_ack
			|| (stat_wr && !pwdata[STAT_LOWER_IRQ_BIT])) begin
			lower_channel_irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_channel_irq_flag_q <= 1'b0;
		end else if (upper_set) begin
			upper_channel_irq_flag_q <= 1'b1;
		end else if (upper_start || upper_irq_ack
			|| (stat_wr && !pwdata[STAT_UPPER_IRQ_BIT])) begin
			upper_channel_irq_flag_q <= 1'b0;
		end
	end

	assign lower_irq = lower_channel_irq_flag_q;
	assign upper_irq = upper_channel_irq_flag_q & upper_channel_irq_enable_q;

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_channel_mode_q <= MODE_RESET;
		end else if (is_write(ADDR_LOWER_MODE)) begin
			lower_channel_mode_q <= pwdata[7:0] & ~(8'h01 << MODE_START_BIT);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_channel_mode_q <= MODE_RESET;
		end else if (is_write(ADDR_UPPER_MODE)) begin
			upper_channel_mode_q <= pwdata[7:0] & ~(8'h01 << MODE_START_BIT);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_modulo_q       <= MODULO_RESET;
			lower_modulo_q       <= MODULO_RESET;
			high_period_modulo_q <= MODULO_RESET;
		end else begin
			if (is_write(ADDR_UPPER_MODULO)) begin
				upper_modulo_q <= pwdata[7:0];
			end
			if (is_write(ADDR_LOWER_MODULO)) begin
				lower_modulo_q <= pwdata[7:0];
			end
			if (is_write(ADDR_HIGH_MODULO)) begin
				high_period_modulo_q <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_channel_irq_enable_q <= 1'b0;
		end else if (stat_wr) begin
			upper_channel_irq_enable_q <= pwdata[STAT_UPPER_IE_BIT];
		end
	end

	// Control register; level bit reloaded from buffer on upper interrupt in carrier mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_control_reg_q  <= CTRL_RESET;
			upper_output_enable_q <= 1'b0;
		end else begin
			if (is_write(ADDR_OUTPUT_CTRL)) begin
				output_control_reg_q  <= pwdata[7:0];
				upper_output_enable_q <= pwdata[CTRL_UPPER_OE_BIT];
			end
			if (upper_set && mode == CTG_MODE_CARRIER) begin
				output_control_reg_q[CTRL_LEVEL_BIT] <=
					is_write(ADDR_OUTPUT_CTRL) ? pwdata[CTRL_NEXT_LEVEL_BIT]
					: output_control_reg_q[CTRL_NEXT_LEVEL_BIT];
			end
		end
	end

	// ****************************************
	// Output gating
	// ****************************************
	logic level;
	logic carrier_pulse;

	assign level = output_control_reg_q[CTRL_LEVEL_BIT];
	assign carrier_pulse = output_toggle_ff_q;

	// Gate changes only while carrier is low, keeping pulse widths whole
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gated_q <= 1'b0;
		end else if (!carrier_pulse) begin
			gated_q <= level;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carrier_out_pin  <= 1'b0;
			envelope_out_pin <= 1'b0;
		end else begin
			if (!output_control_reg_q[CTRL_LOWER_OE_BIT]) begin
				carrier_out_pin <= 1'b0;
			end else if (mode != CTG_MODE_CARRIER) begin
				carrier_out_pin <= output_toggle_ff_q;
			end else if (output_control_reg_q[CTRL_STYLE_BIT]) begin
				carrier_out_pin <= level;
			end else begin
				carrier_out_pin <= gated_q & carrier_pulse;
			end
			envelope_out_pin <= upper_output_enable_q & upper_tff_q;
		end
	end

	// ****************************************
	// APB read path
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				ADDR_LOWER_MODE:   prdata_q <= {24'h0, lower_channel_mode_q};
				ADDR_UPPER_MODE:   prdata_q <= {24'h0, upper_channel_mode_q};
				ADDR_UPPER_MODULO: prdata_q <= {24'h0, upper_modulo_q};
				ADDR_LOWER_MODULO: prdata_q <= {24'h0, lower_modulo_q};
				ADDR_HIGH_MODULO:  prdata_q <= {24'h0, high_period_modulo_q};
				ADDR_OUTPUT_CTRL:  prdata_q <= {24'h0, output_control_reg_q[7:5],
					upper_output_enable_q, output_control_reg_q[3:0]};
				ADDR_STATUS:       prdata_q <= {29'h0, upper_channel_irq_enable_q,
					lower_channel_irq_flag_q, upper_channel_irq_flag_q};
				ADDR_COUNTS:       prdata_q <= {16'h0, upper_count_q, lower_count_q};
				default:           prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = (rd_acc | wr_acc) & ~known;
endmodule
`default_nettype wire

//--- tb/cascaded_timer_carrier_gen_bench.sv
// Bench for the cascaded timer and carrier generator.
// Assumes ctg_top with a zero-wait APB slave and the pin load model.
`timescale 1ns/100ps
`default_nettype none
module cascaded_timer_carrier_gen_bench
	import ctg_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        upper_irq_ack = 1'b0;
	logic        lower_irq_ack = 1'b0;
	logic        upper_irq;
	logic        lower_irq;
	logic        carrier_out_pin;
	logic        envelope_out_pin;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          pulses;
	int          bad_count;
	ctg_top ctg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .upper_irq_ack, .lower_irq_ack, .upper_irq, .lower_irq,
		.carrier_out_pin, .envelope_out_pin);
	ctg_load_model #(.WIDTH(3)) ctg_load_model_i (.pclk, .presetn, .pin(carrier_out_pin),
		.pulses, .bad_count);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h0, r, e);
		check(what, exp, r);
	endtask
	task automatic wait_flag(input logic up, output int n);
		n = 0;
		while (((up ? upper_irq : lower_irq) !== 1'b1) && n < 9000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic ack(input logic up);
		upper_irq_ack <= up;
		lower_irq_ack <= !up;
		@(posedge pclk);
		upper_irq_ack <= 1'b0;
		lower_irq_ack <= 1'b0;
	endtask
	task automatic next_upper();
		int n;
		ack(1'b1);
		@(posedge pclk);
		wait_flag(1'b1, n);
	endtask
	task automatic interval(input logic up, output int n);
		wait_flag(up, n);
		ack(up);
		n = 1;
		do begin
			@(posedge pclk);
			n++;
		end while (((up ? upper_irq : lower_irq) !== 1'b1) && n < 9000);
	endtask
	// ****************************************
	// Clock, timeout and tests
	// ****************************************
	initial begin
		forever #10 pclk = ~pclk;
	end
	initial begin
		forever begin
			@(posedge pclk);
			cyc++;
			if (cyc == 40000) begin
				num_errors++;
				stop_test();
			end
		end
	end
	initial begin
		int          n;
		static int   dv [2:7] = '{2, 1, 1024, 256, 64, 16};
		static int   uv [3:7] = '{32, 4096, 1024, 256, 64};
		logic [31:0] r;
		logic        e;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk("lower mode", ADDR_LOWER_MODE, 32'h0);
		rd_chk("upper mode", ADDR_UPPER_MODE, 32'h0);
		rd_chk("control", ADDR_OUTPUT_CTRL, 32'h0);
		rd_chk("upper modulo", ADDR_UPPER_MODULO, 32'hFF);
		apb(1'b0, 12'hF18, 8'h0, r, e);
		check("unmapped error", 32'h1, {31'h0, e});
		wr(ADDR_LOWER_MODULO, 8'h01);
		wr(ADDR_UPPER_MODULO, 8'h00);
		wr(ADDR_UPPER_MODE, 8'h22);
		wr(ADDR_LOWER_MODE, 8'h3A);
		repeat (10) @(posedge pclk);
		rd_chk("count held", ADDR_COUNTS, 32'h0);
		rd_chk("start cleared", ADDR_LOWER_MODE, 32'h32);
		for (int c = 2; c <= 7; c++) begin
			wr(ADDR_LOWER_MODE, {1'b0, c[2:0], 4'hE});
			interval(1'b0, n);
			check("cascade interval", 32'(2 * dv[c]), 32'(n));
		end
		wr(ADDR_LOWER_MODE, 8'h08);
		wr(ADDR_STATUS, 8'h04);
		for (int u = 3; u <= 7; u++) begin
			wr(ADDR_UPPER_MODE, {1'b0, u[2:0], 4'hC});
			interval(1'b1, n);
			check("upper interval", 32'(uv[u]), 32'(n));
		end
		wr(ADDR_UPPER_MODE, 8'h08);
		wr(ADDR_HIGH_MODULO, 8'h02);
		wr(ADDR_LOWER_MODULO, 8'h02);
		wr(ADDR_UPPER_MODULO, 8'h03);
		wr(ADDR_OUTPUT_CTRL, 8'h15);
		wr(ADDR_STATUS, 8'h04);
		wr(ADDR_LOWER_MODE, 8'h3F);
		wr(ADDR_UPPER_MODE, 8'h2C);
		check("pin before reload", 32'h0, {31'h0, carrier_out_pin});
		wait_flag(1'b1, n);
		check("upper flag", 32'h1, {31'h0, upper_irq});
		ack(1'b1);
		rd_chk("level reloaded", ADDR_OUTPUT_CTRL, 32'h1D);
		check("envelope toggled", 32'h1, {31'h0, envelope_out_pin});
		repeat (60) @(posedge pclk);
		check("carrier pulses", 32'h1, {31'h0, pulses > 0});
		wr(ADDR_OUTPUT_CTRL, 8'h19);
		next_upper();
		repeat (10) @(posedge pclk);
		check("pin level zero", 32'h0, {31'h0, carrier_out_pin});
		check("pulse widths", 32'h0, 32'(bad_count));
		wr(ADDR_OUTPUT_CTRL, 8'h17);
		next_upper();
		repeat (3) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			check("steady high", 32'h1, {31'h0, carrier_out_pin});
			@(posedge pclk);
		end
		wr(ADDR_OUTPUT_CTRL, 8'h16);
		repeat (3) @(posedge pclk);
		check("pin disabled", 32'h0, {31'h0, carrier_out_pin});
		stop_test();
	end
endmodule
`default_nettype wire

//--- tb/ctg_load_model.sv
// Load on the carrier pin: counts high pulses and their widths.
// Assumes one sample per clock; WIDTH is the expected pulse width.
`timescale 1ns/100ps
`default_nettype none
module ctg_load_model #(
	parameter int WIDTH = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output var  int   pulses,
	output var  int   bad_count
);
	int run;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run <= 0;
			pulses <= 0;
			bad_count <= 0;
		end else if (pin === 1'b1) begin
			run <= run + 1;
		end else begin
			if (run != 0) begin
				pulses <= pulses + 1;
				if (run != WIDTH) begin
					bad_count <= bad_count + 1;
				end
			end
			run <= 0;
		end
	end
endmodule
`default_nettype wire

//--- tb/ctg_top_sva.sv
// Checker for the timer pair: timing relations seen at the top ports.
// Assumes the package field positions and a zero-wait APB slave.
`timescale 1ns/100ps
`default_nettype none
module ctg_top_sva
	import ctg_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        upper_irq_ack,
	input wire logic        lower_irq_ack,
	input wire logic        upper_irq,
	input wire logic        lower_irq,
	input wire logic        carrier_out_pin,
	input wire logic        envelope_out_pin
);
	// ****************************************
	// Helper logic
	// ****************************************
	logic       mapped;
	logic       acc;
	logic [1:0] oe_q;
	assign mapped = paddr inside {ADDR_LOWER_MODE, ADDR_UPPER_MODE, ADDR_UPPER_MODULO,
		ADDR_LOWER_MODULO, ADDR_HIGH_MODULO, ADDR_OUTPUT_CTRL, ADDR_STATUS, ADDR_COUNTS};
	assign acc = psel && penable;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q <= 2'h0;
		end else if (acc && pwrite && pstrb[0] && paddr == ADDR_OUTPUT_CTRL) begin
			oe_q <= {pwdata[CTRL_UPPER_OE_BIT], pwdata[CTRL_LOWER_OE_BIT]};
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_always: assert property (pready)
		else $error("ready low");
	a_slverr_unmapped: assert property (pslverr == (acc && !mapped))
		else $error("error response wrong");
	a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_start_reads_zero: assert property (acc && !pwrite && (paddr == ADDR_LOWER_MODE ||
		paddr == ADDR_UPPER_MODE) |-> !prdata[MODE_START_BIT]) else $error("start bit reads one");
	a_lower_flag_holds: assert property (lower_irq && !lower_irq_ack && !(acc && pwrite)
		|=> lower_irq) else $error("lower flag dropped");
	a_upper_flag_holds: assert property (upper_irq && !upper_irq_ack && !(acc && pwrite)
		|=> upper_irq) else $error("upper flag dropped");
	a_reset_pins_low: assert property ($rose(presetn) |-> !carrier_out_pin &&
		!envelope_out_pin && !lower_irq && !upper_irq) else $error("pin high after reset");
	a_carrier_oe_low: assert property (!oe_q[0] && !$past(oe_q[0]) |-> !carrier_out_pin)
		else $error("carrier pin high while disabled");
	a_envelope_oe_low: assert property (!oe_q[1] && !$past(oe_q[1]) |-> !envelope_out_pin)
		else $error("envelope pin high while disabled");
endmodule
bind ctg_top ctg_top_sva ctg_top_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .upper_irq_ack, .lower_irq_ack, .upper_irq,
	.lower_irq, .carrier_out_pin, .envelope_out_pin);
`default_nettype wire
